// ### logic/dma_lock_gate.sv
// Hold-off of DMA bus requests across runs of bus-locking instructions.
`timescale 1ns/1ns
`default_nettype none
module dma_lock_gate (
	input  wire logic sys_clk,
	input  wire logic resetn,
	input  wire logic instr_start,
	input  wire logic instr_locking,
	input  wire logic instr_done,
	input  wire logic dma_req,
	output logic      dma_grant,
	output logic      lock_active
);
	typedef struct packed {
		logic locked;
		logic grant;
	} gate_state_t;

	gate_state_t s_q;
	gate_state_t s_d;

	always_comb begin
		s_d = s_q;
		// Lock spans from the start of a locking instruction; a following locking one keeps it.
		if (instr_start && instr_locking) begin
			s_d.locked = 1'b1;
		end else if (instr_done && !instr_locking) begin
			s_d.locked = 1'b0;
		end else if (instr_start && !instr_locking) begin
			s_d.locked = 1'b0;
		end
		// Grant only at a boundary of a non-locking instruction.
		if (!dma_req) begin
			s_d.grant = 1'b0;
		end else if (instr_done && !instr_locking) begin
			s_d.grant = 1'b1;
		end else if (s_d.locked) begin
			s_d.grant = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign dma_grant   = s_q.grant;
	assign lock_active = s_q.locked;

	property p_no_grant_locked;
		@(posedge sys_clk) disable iff (!resetn)
		(instr_start && instr_locking) |=> !dma_grant;
	endproperty
	a_no_grant_locked: assert property (p_no_grant_locked) else $error("grant during lock");

	property p_grant_boundary;
		@(posedge sys_clk) disable iff (!resetn)
		(dma_req && instr_done && !instr_locking) |=> dma_grant;
	endproperty
	a_grant_boundary: assert property (p_grant_boundary) else $error("grant missed");
endmodule // dma_lock_gate
`default_nettype wire

// ### logic/exec_quirks.sv
// Retirement-side execution quirk unit: push value, step trap, fault frame, shift mask, DMA gate.
// Summary of operation
// - Push-stack-pointer stores the stack pointer value held before the decrement.
// - Single-step trap is suppressed after software-interrupt opcodes cc and cd.
// - Divide error frame carries the faulting instruction's segment and offset.
// - Only the low five bits of a shift or rotate count are used.
// - DMA requests refused throughout a run of bus-locking instructions.
`timescale 1ns/1ns
`default_nettype none
module exec_quirks (
	input  wire logic             sys_clk,
	input  wire logic             resetn,
	input  wire logic             instr_start,
	input  wire logic             instr_locking_start,
	input  wire logic             retire_valid,
	input  wire quirk_pkg::retire_t retire,
	input  wire logic             single_step_flag,
	input  wire logic             dma_req,
	output logic                  push_valid,
	output logic [15:0]           push_data,
	output quirk_pkg::trap_t      trap,
	output logic [4:0]            shift_amount,
	output logic                  dma_grant,
	output logic                  lock_active
);
	typedef struct packed {
		logic             push_valid;
		logic [15:0]      push_data;
		quirk_pkg::trap_t trap;
		logic [4:0]       shift_amount;
	} core_state_t;

	core_state_t s_q;
	core_state_t s_d;

	function automatic logic is_soft_int(input logic [7:0] op);
		return (op == quirk_pkg::OP_INT3) || (op == quirk_pkg::OP_INT_IMM);
	endfunction

	logic gate_grant;
	logic gate_lock;

	always_comb begin
		s_d = s_q;
		s_d.push_valid = 1'b0;
		s_d.trap = '0;
		if (retire_valid) begin
			// Old value is stored so code that probes the push order sees the newer behaviour.
			if (retire.opcode == quirk_pkg::OP_PUSH_STK) begin
				s_d.push_valid = 1'b1;
				s_d.push_data  = retire.sp;
			end
			s_d.shift_amount = retire.shift_count[4:0] & quirk_pkg::SHIFT_MASK;
			// A divide fault outranks the step trap; no step trap is raised for that instruction.
			if (retire.div_fault) begin
				s_d.trap.valid  = 1'b1;
				s_d.trap.vector = quirk_pkg::DIV_ERR_VECTOR;
				s_d.trap.seg    = retire.seg;
				s_d.trap.ofs    = retire.ofs;
			end else if (single_step_flag && !is_soft_int(retire.opcode)) begin
				s_d.trap.valid  = 1'b1;
				s_d.trap.vector = quirk_pkg::STEP_VECTOR;
				s_d.trap.seg    = retire.seg;
				s_d.trap.ofs    = retire.next_ofs;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	dma_lock_gate u_gate (
		.sys_clk       (sys_clk),
		.resetn        (resetn),
		.instr_start   (instr_start),
		.instr_locking (instr_start ? instr_locking_start : retire.locking),
		.instr_done    (retire_valid),
		.dma_req       (dma_req),
		.dma_grant     (gate_grant),
		.lock_active   (gate_lock)
	);

	assign push_valid   = s_q.push_valid;
	assign push_data    = s_q.push_data;
	assign trap         = s_q.trap;
	assign shift_amount = s_q.shift_amount;
	assign dma_grant    = gate_grant;
	assign lock_active  = gate_lock;

	property p_push_old;
		@(posedge sys_clk) disable iff (!resetn)
		(retire_valid && retire.opcode == quirk_pkg::OP_PUSH_STK)
			|=> (push_valid && push_data == $past(retire.sp));
	endproperty
	a_push_old: assert property (p_push_old) else $error("push value wrong");

	property p_no_step_int;
		@(posedge sys_clk) disable iff (!resetn)
		(retire_valid && !retire.div_fault && is_soft_int(retire.opcode)) |=> !trap.valid;
	endproperty
	a_no_step_int: assert property (p_no_step_int) else $error("step after int");

	property p_step_other;
		@(posedge sys_clk) disable iff (!resetn)
		(retire_valid && !retire.div_fault && single_step_flag && !is_soft_int(retire.opcode))
			|=> (trap.valid && trap.vector == quirk_pkg::STEP_VECTOR);
	endproperty
	a_step_other: assert property (p_step_other) else $error("step trap missing");

	property p_div_frame;
		@(posedge sys_clk) disable iff (!resetn)
		(retire_valid && retire.div_fault) |=> (trap.valid && trap.vector == 8'h00
			&& trap.ofs == $past(retire.ofs) && trap.seg == $past(retire.seg));
	endproperty
	a_div_frame: assert property (p_div_frame) else $error("divide frame wrong");

	property p_shift_mod;
		@(posedge sys_clk) disable iff (!resetn)
		retire_valid |=> (shift_amount == ($past(retire.shift_count) % 8'd32));
	endproperty
	a_shift_mod: assert property (p_shift_mod) else $error("shift count not mod 32");

	property p_lock_holds;
		@(posedge sys_clk) disable iff (!resetn)
		(lock_active && !retire_valid && !instr_start) |=> lock_active;
	endproperty
	a_lock_holds: assert property (p_lock_holds) else $error("lock dropped early");

	// Instructions other than the push leave the stack write quiet and the data alone.
	property p_push_quiet;
		@(posedge sys_clk) disable iff (!resetn)
		!(retire_valid && retire.opcode == quirk_pkg::OP_PUSH_STK) |=> !push_valid;
	endproperty
	a_push_quiet: assert property (p_push_quiet) else $error("stray push strobe");

	property p_push_keep;
		@(posedge sys_clk) disable iff (!resetn)
		!(retire_valid && retire.opcode == quirk_pkg::OP_PUSH_STK) |=> $stable(push_data);
	endproperty
	a_push_keep: assert property (p_push_keep) else $error("push data moved");

	// A step trap resumes after the instruction, unlike the divide frame.
	property p_step_frame;
		@(posedge sys_clk) disable iff (!resetn)
		(retire_valid && !retire.div_fault && single_step_flag && !is_soft_int(retire.opcode))
			|=> (trap.seg == $past(retire.seg) && trap.ofs == $past(retire.next_ofs));
	endproperty
	a_step_frame: assert property (p_step_frame) else $error("step frame wrong");

	property p_trap_idle;
		@(posedge sys_clk) disable iff (!resetn)
		!retire_valid |=> !trap.valid;
	endproperty
	a_trap_idle: assert property (p_trap_idle) else $error("trap without boundary");

	// Both conditions at one boundary must still yield the divide frame.
	property p_div_first;
		@(posedge sys_clk) disable iff (!resetn)
		(retire_valid && retire.div_fault && single_step_flag)
			|=> (trap.valid && trap.vector == quirk_pkg::DIV_ERR_VECTOR);
	endproperty
	a_div_first: assert property (p_div_first) else $error("divide not first");

	property p_shift_keep;
		@(posedge sys_clk) disable iff (!resetn)
		!retire_valid |=> $stable(shift_amount);
	endproperty
	a_shift_keep: assert property (p_shift_keep) else $error("shift count moved");

	// A run of locking instructions: the start raises the lock, a locking retire keeps it.
	sequence s_lock_begins;
		instr_start && instr_locking_start;
	endsequence

	sequence s_locked_retire;
		retire_valid && !instr_start && retire.locking;
	endsequence

	sequence s_lock_in_force;
		lock_active && !dma_grant;
	endsequence

	property p_lock_begins;
		@(posedge sys_clk) disable iff (!resetn)
		s_lock_begins |=> s_lock_in_force;
	endproperty
	a_lock_begins: assert property (p_lock_begins) else $error("lock not raised");

	property p_run_kept;
		@(posedge sys_clk) disable iff (!resetn)
		s_lock_begins ##1 s_locked_retire |=> s_lock_in_force;
	endproperty
	a_run_kept: assert property (p_run_kept) else $error("lock lost in run");

	// A plain instruction that retires with a request pending, and no instruction start in that cycle, releases the bus at once.
	sequence s_plain_boundary;
		retire_valid && !instr_start && !retire.locking && dma_req;
	endsequence

	property p_plain_grant;
		@(posedge sys_clk) disable iff (!resetn)
		s_plain_boundary |=> (dma_grant && !lock_active);
	endproperty
	a_plain_grant: assert property (p_plain_grant) else $error("plain boundary no grant");

	// Grant and lock never stand together; a lock start always takes the bus back.
	property p_grant_excl;
		@(posedge sys_clk) disable iff (!resetn)
		dma_grant |-> !lock_active;
	endproperty
	a_grant_excl: assert property (p_grant_excl) else $error("grant under lock");

	property p_grant_drop;
		@(posedge sys_clk) disable iff (!resetn)
		!dma_req |=> !dma_grant;
	endproperty
	a_grant_drop: assert property (p_grant_drop) else $error("grant without request");
endmodule // exec_quirks
`default_nettype wire

// ### logic/quirk_pkg.sv
// Shared constants and carrier types for the execution quirk unit.
`default_nettype none
package quirk_pkg;
	localparam logic [7:0] OP_INT3        = 8'hcc;
	localparam logic [7:0] OP_INT_IMM     = 8'hcd;
	localparam logic [7:0] OP_PUSH_STK    = 8'h54;
	localparam int         SHIFT_BITS     = 5;
	localparam logic [4:0] SHIFT_MASK     = 5'h1f;
	localparam logic [7:0] DIV_ERR_VECTOR = 8'h00;
	localparam logic [7:0] STEP_VECTOR    = 8'h01;
	localparam logic       RST_LOW        = 1'b0;
	localparam logic [15:0] RST_WORD      = 16'h0000;

	// One retired instruction, presented at its boundary.
	typedef struct packed {
		logic [7:0]  opcode;
		logic        locking;
		logic        div_fault;
		logic [15:0] seg;
		logic [15:0] ofs;
		logic [15:0] next_ofs;
		logic [15:0] sp;
		logic [7:0]  shift_count;
	} retire_t;

	// Exception frame handed to the sequencer.
	typedef struct packed {
		logic        valid;
		logic [7:0]  vector;
		logic [15:0] seg;
		logic [15:0] ofs;
	} trap_t;
endpackage : quirk_pkg
`default_nettype wire

// ### verif/dma_requester.sv
// Behavioural DMA controller that asks for the system bus.
`timescale 1ns/1ns
`default_nettype none
module dma_requester (
	input  wire logic sys_clk,
	input  wire logic resetn,
	input  wire logic want,
	input  wire logic dma_grant,
	output logic      dma_req
);
	// A refused request is held, never dropped, as a real controller does.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) dma_req <= 1'b0;
		else if (!want && dma_grant) dma_req <= 1'b0;
		else if (want) dma_req <= 1'b1;
	end
endmodule // dma_requester
`default_nettype wire

// ### verif/test_exec_quirks.sv
// Self-checking bench for the execution quirk unit.
`timescale 1ns/1ns
`default_nettype none
module test_exec_quirks;
	logic                 sys_clk = 1'b0;
	logic                 resetn = 1'b0;
	logic                 st = 1'b0;
	logic                 stl = 1'b0;
	logic                 rv = 1'b0;
	logic                 ssf = 1'b0;
	logic                 want = 1'b0;
	quirk_pkg::retire_t   r = '0;
	quirk_pkg::trap_t     trap;
	logic                 push_valid, dma_grant, lock_active, dma_req;
	logic [15:0]          push_data;
	logic [4:0]           shift_amount;
	int                   error_cnt = 0;
	int                   n_tests = 0;
	int                   cyc = 0;
	logic [7:0]           ops [3] = '{8'hcc, 8'hcd, 8'h90};
	logic [7:0]           cnts [4] = '{8'h24, 8'h1f, 8'h20, 8'hff};

	exec_quirks u_exec_quirks (.sys_clk(sys_clk), .resetn(resetn), .instr_start(st),
		.instr_locking_start(stl), .retire_valid(rv), .retire(r), .single_step_flag(ssf),
		.dma_req(dma_req), .push_valid(push_valid), .push_data(push_data), .trap(trap),
		.shift_amount(shift_amount), .dma_grant(dma_grant), .lock_active(lock_active));
	dma_requester u_dma_requester (.sys_clk(sys_clk), .resetn(resetn), .want(want),
		.dma_grant(dma_grant), .dma_req(dma_req));

	always #20 sys_clk = ~sys_clk;
	// The whole run needs under 100 cycles, so this ceiling only catches a hang.
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 2000) begin
			error_cnt++;
			close_out();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask

	// Starts one instruction, retires it a cycle later, returns when outputs settle.
	task automatic go(input logic [7:0] op, input logic lk, input logic dv, input logic [7:0] c);
		st = 1'b1;
		stl = lk;
		@(negedge sys_clk);
		st = 1'b0;
		stl = 1'b0;
		r = '{op, lk, dv, 16'h1234, 16'h0100, 16'h0102, 16'h2000, c};
		rv = 1'b1;
		@(negedge sys_clk);
		rv = 1'b0;
	endtask

	task automatic t_push();
		go(quirk_pkg::OP_PUSH_STK, 1'b0, 1'b0, 8'h00);
		chk(16'(push_valid), 16'h0001, "push strobe");
		chk(push_data, 16'h2000, "pushed value");
		$display("push test done");
	endtask

	task automatic t_step();
		ssf = 1'b1;
		foreach (ops[i]) begin
			go(ops[i], 1'b0, 1'b0, 8'h00);
			chk(16'(trap.valid), 16'(ops[i] == 8'h90), "step trap");
		end
		go(8'h90, 1'b0, 1'b0, 8'h00);
		chk(16'(trap.vector), 16'(quirk_pkg::STEP_VECTOR), "step vector");
		chk(trap.seg, 16'h1234, "step segment");
		chk(trap.ofs, 16'h0102, "step offset");
		chk(16'(push_valid), 16'h0000, "no push strobe");
		ssf = 1'b0;
		$display("step test done");
	endtask

	// The step flag stays set so the divide frame must win over the step trap.
	task automatic t_div();
		ssf = 1'b1;
		go(8'hf6, 1'b0, 1'b1, 8'h00);
		chk(16'(trap.valid), 16'h0001, "divide trap");
		chk(16'(trap.vector), 16'h0000, "divide vector");
		chk(trap.seg, 16'h1234, "fault segment");
		chk(trap.ofs, 16'h0100, "fault offset");
		ssf = 1'b0;
		$display("divide test done");
	endtask

	task automatic t_shift();
		foreach (cnts[i]) begin
			go(8'hd3, 1'b0, 1'b0, cnts[i]);
			chk(16'(shift_amount), 16'(cnts[i] % 32), "shift count");
		end
		$display("shift test done");
	endtask

	task automatic t_lock();
		want = 1'b1;
		go(8'h87, 1'b1, 1'b0, 8'h00);
		chk(16'(lock_active), 16'h0001, "lock flag");
		chk(16'(dma_grant), 16'h0000, "grant in lock");
		go(8'h87, 1'b1, 1'b0, 8'h00);
		chk(16'(dma_grant), 16'h0000, "grant in run");
		go(8'h90, 1'b0, 1'b0, 8'h00);
		chk(16'(dma_grant), 16'h0001, "grant after run");
		chk(16'(lock_active), 16'h0000, "lock released");
		want = 1'b0;
		repeat (3) @(negedge sys_clk);
		$display("lock test done");
	endtask

	// A reset in mid-run must drop a standing lock and the held push data.
	task automatic t_reset();
		go(8'h87, 1'b1, 1'b0, 8'h00);
		resetn = 1'b0;
		@(negedge sys_clk);
		chk(16'(lock_active), 16'h0000, "lock after reset");
		chk(16'(dma_grant), 16'h0000, "grant after reset");
		chk(push_data, 16'h0000, "push data after reset");
		resetn = 1'b1;
		repeat (2) @(negedge sys_clk);
		$display("reset test done");
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		repeat (10) @(negedge sys_clk);
		resetn = 1'b1;
		@(negedge sys_clk);
		t_push();
		t_step();
		t_div();
		t_shift();
		t_lock();
		t_reset();
		close_out();
	end
endmodule // test_exec_quirks
`default_nettype wire
